// file: shared/itc_div_if.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Divider request and result bundle
// ----------------------------------------------------------------------------
interface itc_div_if;
  logic start;
  logic [24:0] dividend;
  logic [16:0] divisor;
  logic done;
  logic [24:0] quotient;

  modport master (output start, output dividend, output divisor,
                  input done, input quotient);
  modport slave (input start, input dividend, input divisor,
                 output done, output quotient);
endinterface
`default_nettype wire

// file: shared/itc_pkg.sv
`default_nettype none
// ----------------------------------------------------------------------------
// Interval timer correction constants
// ----------------------------------------------------------------------------
package itc_pkg;

  // System clock rate in MHz (4 ns period).
  localparam int SYS_CLK_MHZ = 250;

  // Low-speed oscillator stabilisation wait, in microseconds and in cycles.
  localparam int STAB_TIME_US = 210;
  localparam int STAB_CYCLES = STAB_TIME_US * SYS_CLK_MHZ;

  // Correction arithmetic terms.
  localparam int TARGET_S = 20;
  localparam int LSO_NOMINAL_HZ = 15000;
  localparam int IDEAL_MEAS = 533;
  localparam int TIMER_DIV_RATIO = 8;
  localparam logic [24:0] CORR_DIVIDEND =
    25'(TARGET_S * LSO_NOMINAL_HZ * IDEAL_MEAS / TIMER_DIV_RATIO);

  // Interval timer prescaler: last count of the divide-by-8 stage.
  localparam logic [2:0] PRESC_LAST = 3'(TIMER_DIV_RATIO - 1);

  // Reset value of the interval compare register (about 20 s at nominal rate).
  localparam logic [15:0] COMPARE_RESET = 16'h927B;
  localparam logic [15:0] COMPARE_MAX = 16'hFFFF;

  // Conversion result threshold for the buzzer alarm.
  localparam logic [15:0] ALARM_LEVEL = 16'h0E00;

  // Buzzer toggles every second low-speed falling edge, giving the rate / 4.
  localparam logic [0:0] BUZ_HALF_LAST = 1'h1;

  // Divider geometry.
  localparam int DIV_STEPS = 25;
  localparam logic [4:0] DIV_LAST_STEP = 5'(DIV_STEPS - 1);

  // Sequencer states.
  typedef enum logic [2:0] {
    ITC_STAB, ITC_MEAS, ITC_DIV, ITC_SLEEP, ITC_CONV, ITC_BUZZ
  } itc_state_t;

endpackage
`default_nettype wire

// file: src/itc_divider.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Restoring divider, one quotient bit per enabled cycle
// ----------------------------------------------------------------------------
module itc_divider
  import itc_pkg::*;
(
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Request and result.
  itc_div_if.slave div
);

  logic busy_q;
  logic [4:0] step_q;
  logic [17:0] rem_q;
  logic [24:0] dvd_q;
  logic [24:0] quo_q;
  logic [16:0] dvs_q;
  logic [24:0] result_q;
  logic done_q;

  // One trial subtraction of the shifted remainder.
  wire [17:0] rem_shift = {rem_q[16:0], dvd_q[24]};
  wire fits = rem_shift >= {1'b0, dvs_q};
  wire [17:0] rem_next = fits ? rem_shift - {1'b0, dvs_q} : rem_shift;
  wire last_step = busy_q && (step_q == DIV_LAST_STEP);

  // Iteration; the quotient is truncated toward zero by construction.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      step_q <= 5'h00;
      rem_q <= 18'h00000;
      dvd_q <= 25'h0000000;
      quo_q <= 25'h0000000;
      dvs_q <= 17'h00000;
    end else if (ce) begin
      if (!busy_q && div.start) begin
        busy_q <= 1'b1;
        step_q <= 5'h00;
        rem_q <= 18'h00000;
        dvd_q <= div.dividend;
        dvs_q <= div.divisor;
      end else if (busy_q) begin
        rem_q <= rem_next;
        dvd_q <= {dvd_q[23:0], 1'b0};
        quo_q <= {quo_q[23:0], fits};
        step_q <= step_q + 5'h01;
        busy_q <= !last_step;
      end
    end
  end

  // The visible result only changes once the last bit is known, so a reader
  // never sees a half-built quotient.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_q <= 25'h0000000;
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= last_step;
      if (last_step) begin
        result_q <= {quo_q[23:0], fits};
      end
    end
  end

  assign div.done = done_q;
  assign div.quotient = result_q;

endmodule
`default_nettype wire

// file: src/itc_top.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - The compare value is 19987500 divided by the measurement, minus one, saturating at 0xFFFF.
// - The measurement is the captured count register value plus one, in fast-clock cycles.
// - The ideal measurement of 533 fast cycles per slow period scales the dividend.
// - The interval timer counts the slow clock divided by 8.
// - Compare value plus one times the divided slow period gives 20 s.
// - The correction is repeated in operation, not computed only once.
// - Below 0x0E00 after a wake the block corrects, restarts the timer and sleeps again.
// - At or above 0x0E00 the buzzer output is enabled instead of sleeping.
// - A compare match raises a wake request about every 20 s and starts one conversion.
// - At start the block waits 210 us, enables wake requests, corrects, then starts the timer.
// - The 8 MHz fast oscillator is the measurement count clock.
// - The first capture after the measurement starts is discarded; the second is used.
// - The interval timer is a 16-bit counter with a 16-bit compare register.
module itc_top
  import itc_pkg::*;
#(
  parameter int STAB_WAIT = STAB_CYCLES
) (
  // Clock, reset and enable.
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  // Oscillator pins, asynchronous to SYS_CLK.
  input wire logic LSO_CLK_PIN,
  input wire logic HSO_CLK_PIN,
  // Converter handshake, same clock domain.
  output logic CONV_START,
  input wire logic CONV_DONE,
  input wire logic [15:0] CONV_RESULT,
  // Buzzer control.
  input wire logic BUZZER_STOP,
  output logic BUZZER_OUTPUT_PIN,
  output logic BUZZER_ACTIVE,
  // Status.
  output logic STOP_MODE,
  output logic WAKE_IRQ,
  output logic WAKE_IRQ_ENABLED,
  output logic [15:0] INTERVAL_COMPARE_VALUE,
  output logic [15:0] CAPTURE_COUNT
);

  // --------------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // --------------------------------------------------------------------------
  logic [2:0] lso_sync_q;
  logic [2:0] hso_sync_q;

  // Third stage only feeds the edge detectors; stage one feeds stage two only.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      lso_sync_q <= 3'h0;
      hso_sync_q <= 3'h0;
    end else if (CLK_EN) begin
      lso_sync_q <= {lso_sync_q[1:0], LSO_CLK_PIN};
      hso_sync_q <= {hso_sync_q[1:0], HSO_CLK_PIN};
    end
  end

  wire lso_fall = lso_sync_q[2] && !lso_sync_q[1];
  wire hso_rise = hso_sync_q[1] && !hso_sync_q[2];

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  itc_state_t state_q, state_d;
  logic [16:0] stab_cnt_q;
  logic irq_en_q;
  logic meas_first_q;
  logic [15:0] hs_cnt_q;
  logic [15:0] cap_q;
  logic [15:0] cmp_q;
  logic timer_run_q;
  logic [2:0] presc_q;
  logic [15:0] tmr_q;
  logic wake_q;
  logic conv_start_q;
  logic buz_en_q;
  logic buz_half_q;
  logic buz_pin_q;

  itc_div_if div_bus ();

  wire stab_done = stab_cnt_q == 17'(STAB_WAIT - 1);
  wire capture_ok = (state_q == ITC_MEAS) && lso_fall && !meas_first_q;
  wire tmr_tick = timer_run_q && lso_fall && (presc_q == PRESC_LAST);
  wire match = tmr_tick && (tmr_q == cmp_q);
  wire alarm = CONV_RESULT >= ALARM_LEVEL;

  // Measurement is captured count plus one; the divider starts in the capture cycle.
  assign div_bus.start = capture_ok;
  assign div_bus.dividend = CORR_DIVIDEND;
  assign div_bus.divisor = {1'b0, cap_d_value()} + 17'h00001;

  // Quotient minus one, held within the 16-bit compare register.
  wire [24:0] quo = div_bus.quotient;
  wire quo_big = quo > 25'({1'b0, COMPARE_MAX} + 17'h00001);
  wire [15:0] new_cmp = (quo == 25'h0000000) ? 16'h0000 :
                        quo_big ? COMPARE_MAX : 16'(quo - 25'h0000001);

  // Value being captured this cycle, so the divisor follows it directly.
  function automatic logic [15:0] cap_d_value();
    return hs_cnt_q;
  endfunction

  // Next state: wait, measure, divide, sleep, convert, and alarm if needed.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ITC_STAB: if (stab_done) state_d = ITC_MEAS;
      ITC_MEAS: if (capture_ok) state_d = ITC_DIV;
      ITC_DIV: if (div_bus.done) state_d = ITC_SLEEP;
      ITC_SLEEP: if (match) state_d = ITC_CONV;
      ITC_CONV: if (CONV_DONE) state_d = alarm ? ITC_BUZZ : ITC_MEAS;
      ITC_BUZZ: if (BUZZER_STOP) state_d = ITC_MEAS;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_q <= ITC_STAB;
      stab_cnt_q <= 17'h00000;
      irq_en_q <= 1'b0;
    end else if (CLK_EN) begin
      state_q <= state_d;
      if (state_q == ITC_STAB && !stab_done) begin
        stab_cnt_q <= stab_cnt_q + 17'h00001;
      end
      if (state_q == ITC_STAB && stab_done) begin
        irq_en_q <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Slow-period measurement on fast-clock edges
  // --------------------------------------------------------------------------
  // The first slow edge only starts the count; a partial period is never used.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      meas_first_q <= 1'b1;
      hs_cnt_q <= 16'h0000;
      cap_q <= 16'h0000;
    end else if (CLK_EN) begin
      if (state_q != ITC_MEAS) begin
        meas_first_q <= 1'b1;
        hs_cnt_q <= 16'h0000;
      end else if (lso_fall) begin
        meas_first_q <= 1'b0;
        hs_cnt_q <= 16'h0000;
        if (!meas_first_q) begin
          cap_q <= hs_cnt_q;
        end
      end else if (hso_rise && hs_cnt_q != COMPARE_MAX) begin
        hs_cnt_q <= hs_cnt_q + 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interval timer, compare register and wake request
  // --------------------------------------------------------------------------
  // The timer is stopped while correcting so the new period starts clean.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cmp_q <= COMPARE_RESET;
      timer_run_q <= 1'b0;
      presc_q <= 3'h0;
      tmr_q <= 16'h0000;
      wake_q <= 1'b0;
      conv_start_q <= 1'b0;
    end else if (CLK_EN) begin
      wake_q <= match && irq_en_q;
      conv_start_q <= match && irq_en_q;
      if (state_q == ITC_DIV && div_bus.done) begin
        cmp_q <= new_cmp;
        timer_run_q <= 1'b1;
        presc_q <= 3'h0;
        tmr_q <= 16'h0000;
      end else if (match) begin
        timer_run_q <= 1'b0;
        presc_q <= 3'h0;
        tmr_q <= 16'h0000;
      end else if (timer_run_q && lso_fall) begin
        presc_q <= presc_q + 3'h1;
        if (tmr_tick) begin
          tmr_q <= tmr_q + 16'h0001;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Buzzer output at the slow rate divided by four
  // --------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      buz_en_q <= 1'b0;
      buz_half_q <= 1'b0;
      buz_pin_q <= 1'b0;
    end else if (CLK_EN) begin
      buz_en_q <= state_d == ITC_BUZZ;
      // Cleared on the same edge as the enable, so the pin never stands high while off.
      if (state_d != ITC_BUZZ) begin
        buz_half_q <= 1'b0;
        buz_pin_q <= 1'b0;
      end else if (lso_fall) begin
        buz_half_q <= buz_half_q + 1'b1;
        if (buz_half_q == BUZ_HALF_LAST) begin
          buz_pin_q <= !buz_pin_q;
        end
      end
    end
  end

  itc_divider u_div (
    .clk(SYS_CLK),
    .rst(RST),
    .ce(CLK_EN),
    .div(div_bus)
  );

  // Outputs.
  assign CONV_START = conv_start_q;
  assign BUZZER_OUTPUT_PIN = buz_pin_q;
  assign BUZZER_ACTIVE = buz_en_q;
  assign STOP_MODE = state_q == ITC_SLEEP;
  assign WAKE_IRQ = wake_q;
  assign WAKE_IRQ_ENABLED = irq_en_q;
  assign INTERVAL_COMPARE_VALUE = cmp_q;
  assign CAPTURE_COUNT = cap_q;

endmodule
`default_nettype wire

// file: verification/itc_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Port checks for the interval correction block
// ----------------------------------------------------------------------------
module itc_checker
  import itc_pkg::*;
#(
  parameter int STAB_WAIT = 20
) (
  // Clock and control.
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  input wire logic LSO_CLK_PIN,
  input wire logic HSO_CLK_PIN,
  // Converter and buzzer.
  input wire logic CONV_START,
  input wire logic CONV_DONE,
  input wire logic [15:0] CONV_RESULT,
  input wire logic BUZZER_STOP,
  input wire logic BUZZER_OUTPUT_PIN,
  input wire logic BUZZER_ACTIVE,
  // Status.
  input wire logic STOP_MODE,
  input wire logic WAKE_IRQ,
  input wire logic WAKE_IRQ_ENABLED,
  input wire logic [15:0] INTERVAL_COMPARE_VALUE,
  input wire logic [15:0] CAPTURE_COUNT
);
  logic conv_wait_q;
  logic [31:0] cyc_q;

  // An open conversion request marks the only window where a result counts.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      conv_wait_q <= 1'b0;
      cyc_q <= '0;
    end else begin
      conv_wait_q <= CONV_START | (conv_wait_q & ~CONV_DONE);
      cyc_q <= cyc_q + 32'h1;
    end
  end

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  irq_pulse_a: assert property (WAKE_IRQ |=> !WAKE_IRQ && !CONV_START)
    else $error("wake pulse longer than one cycle");
  irq_conv_a: assert property (WAKE_IRQ |-> CONV_START && !STOP_MODE && $past(STOP_MODE))
    else $error("wake without conversion start");
  stab_wait_a: assert property ($rose(WAKE_IRQ_ENABLED) |->
    cyc_q >= STAB_WAIT - 1 && cyc_q <= STAB_WAIT + 1)
    else $error("wake enable off the settling time");
  arm_order_a: assert property ($rose(STOP_MODE) |-> WAKE_IRQ_ENABLED)
    else $error("timer armed before wake enable");
  cmp_hold_a: assert property ($changed(INTERVAL_COMPARE_VALUE) |-> $rose(STOP_MODE))
    else $error("compare value changed outside a load");
  alarm_set_a: assert property (conv_wait_q && CONV_DONE && CONV_RESULT >= ALARM_LEVEL
    |=> BUZZER_ACTIVE)
    else $error("alarm not raised");
  alarm_skip_a: assert property (conv_wait_q && CONV_DONE && CONV_RESULT < ALARM_LEVEL
    |=> !BUZZER_ACTIVE [*2])
    else $error("alarm raised below level");
  buz_idle_a: assert property (!BUZZER_ACTIVE |-> !BUZZER_OUTPUT_PIN)
    else $error("buzzer pin moves while off");
  buz_stop_a: assert property (BUZZER_ACTIVE && BUZZER_STOP |-> ##[1:2] !BUZZER_ACTIVE)
    else $error("alarm not ended");
  sleep_quiet_a: assert property (STOP_MODE |-> !BUZZER_ACTIVE && !CONV_START)
    else $error("activity while asleep");

  // Main scenarios.
  cover property ($rose(WAKE_IRQ));
  cover property ($rose(BUZZER_ACTIVE));
  cover property ($changed(INTERVAL_COMPARE_VALUE));
endmodule

bind itc_top itc_checker #(.STAB_WAIT(STAB_WAIT)) itc_checker_inst (
  .SYS_CLK(SYS_CLK), .RST(RST), .CLK_EN(CLK_EN), .LSO_CLK_PIN(LSO_CLK_PIN),
  .HSO_CLK_PIN(HSO_CLK_PIN), .CONV_START(CONV_START), .CONV_DONE(CONV_DONE),
  .CONV_RESULT(CONV_RESULT), .BUZZER_STOP(BUZZER_STOP), .BUZZER_OUTPUT_PIN(BUZZER_OUTPUT_PIN),
  .BUZZER_ACTIVE(BUZZER_ACTIVE), .STOP_MODE(STOP_MODE), .WAKE_IRQ(WAKE_IRQ),
  .WAKE_IRQ_ENABLED(WAKE_IRQ_ENABLED), .INTERVAL_COMPARE_VALUE(INTERVAL_COMPARE_VALUE),
  .CAPTURE_COUNT(CAPTURE_COUNT));
`default_nettype wire

// file: verification/test_interval_timer_correction.sv
`timescale 1ns/10ps
`default_nettype none
module test_interval_timer_correction
  import itc_pkg::*;
;
  logic SYS_CLK, RST, CLK_EN, LSO_CLK_PIN, HSO_CLK_PIN, CONV_DONE, BUZZER_STOP;
  logic [15:0] CONV_RESULT, INTERVAL_COMPARE_VALUE, CAPTURE_COUNT;
  logic CONV_START, BUZZER_OUTPUT_PIN, BUZZER_ACTIVE, STOP_MODE, WAKE_IRQ, WAKE_IRQ_ENABLED;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  int per = 2;
  logic stop_prev = 1'b0;
  logic [31:0] exp_q[$];

  itc_top #(.STAB_WAIT(20)) itc_top_inst (
    .SYS_CLK(SYS_CLK), .RST(RST), .CLK_EN(CLK_EN), .LSO_CLK_PIN(LSO_CLK_PIN),
    .HSO_CLK_PIN(HSO_CLK_PIN), .CONV_START(CONV_START), .CONV_DONE(CONV_DONE),
    .CONV_RESULT(CONV_RESULT), .BUZZER_STOP(BUZZER_STOP), .BUZZER_OUTPUT_PIN(BUZZER_OUTPUT_PIN),
    .BUZZER_ACTIVE(BUZZER_ACTIVE), .STOP_MODE(STOP_MODE), .WAKE_IRQ(WAKE_IRQ),
    .WAKE_IRQ_ENABLED(WAKE_IRQ_ENABLED), .INTERVAL_COMPARE_VALUE(INTERVAL_COMPARE_VALUE),
    .CAPTURE_COUNT(CAPTURE_COUNT));

  // ----------------------------------------------------------------------------
  // Clock, oscillators and checking
  // ----------------------------------------------------------------------------
  initial begin
    SYS_CLK = 1'b0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end

  // Fast edge every second cycle; slow falls land on even counts, so the two never
  // reach the synchronisers in one cycle and the capture is exact. The fastest
  // legal pin rates keep the two long timer runs as short as they can be.
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    HSO_CLK_PIN <= cyc[0];
    LSO_CLK_PIN <= (cyc % per >= per / 2);
  end

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits for armed (0), wake (1); a hang is cut short here.
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    while (((sel == 0) ? STOP_MODE : WAKE_IRQ) !== 1'b1 && n < 100000) begin
      @(posedge SYS_CLK);
      n++;
    end
    if (n >= 100000) begin
      err_total++;
      end_sim();
    end
  endtask

  // Each time the timer arms, the oldest note must match capture and compare value.
  always @(posedge SYS_CLK) begin
    stop_prev <= STOP_MODE;
    if (STOP_MODE === 1'b1 && stop_prev === 1'b0) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else check({CAPTURE_COUNT, INTERVAL_COMPARE_VALUE}, exp_q.pop_front());
    end
  end

  initial begin
    #720000;
    err_total++;
    end_sim();
  end

  // ----------------------------------------------------------------------------
  // Main sequence: two wakes, one below and one at the alarm level
  // ----------------------------------------------------------------------------
  initial begin
    int k, q, cmp, t0, tog;
    logic b;
    RST = 1'b1;
    CLK_EN = 1'b1;
    CONV_DONE = 1'b0;
    BUZZER_STOP = 1'b0;
    CONV_RESULT = 16'h0000;
    k = $urandom(44511);
    k = 8500 + $urandom_range(1000);
    per = 2 * k;
    repeat (3) @(posedge SYS_CLK);
    RST <= 1'b0;
    @(posedge SYS_CLK);
    check(INTERVAL_COMPARE_VALUE, 16'h927B);
    check(WAKE_IRQ_ENABLED, 1'b0);
    for (int w = 0; w < 3; w++) begin
      q = 19987500 / (k + 1);
      cmp = (q > 65536) ? 65535 : q - 1;
      exp_q.push_back({k[15:0], cmp[15:0]});
      wait_for(0);
      if (w == 2) break;
      per <= 2;
      t0 = cyc;
      wait_for(1);
      check(CONV_START, 1'b1);
      check((cyc - t0 > (cmp + 1) * 16 - 20) && (cyc - t0 < (cmp + 1) * 16 + 20), 1);
      // The next slow period is set before the result, so the first capture is clean.
      // The last one is short, so its quotient overflows and the compare value saturates.
      k = (w == 1) ? 100 + $urandom_range(150) : 8500 + $urandom_range(1000);
      per <= 2 * k;
      repeat (8) @(posedge SYS_CLK);
      CONV_RESULT <= (w == 0) ? ALARM_LEVEL - 16'h0001 : ALARM_LEVEL;
      CONV_DONE <= 1'b1;
      @(posedge SYS_CLK);
      CONV_DONE <= 1'b0;
      repeat (2) @(posedge SYS_CLK);
      check(BUZZER_ACTIVE, w);
      if (w == 1) begin
        per <= 12;
        tog = 0;
        repeat (480) begin
          b = BUZZER_OUTPUT_PIN;
          @(posedge SYS_CLK);
          if (BUZZER_OUTPUT_PIN !== b) tog++;
        end
        check(tog >= 19 && tog <= 21, 1);
        per <= 2 * k;
        repeat (8) @(posedge SYS_CLK);
        BUZZER_STOP <= 1'b1;
        @(posedge SYS_CLK);
        BUZZER_STOP <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        check(BUZZER_ACTIVE, 1'b0);
      end
    end
    repeat (4) @(posedge SYS_CLK);
    check(exp_q.size(), 0);
    end_sim();
  end
endmodule
`default_nettype wire
